//--- rtl/dprt_consts.vh
`ifndef DPRT_CONSTS_VH
`define DPRT_CONSTS_VH

// System clock period in ns
`define DPRT_TCLK_NS 8

// First-edge command codes on CA4..CA0
`define DPRT_CMD_REF 5'h08
`define DPRT_CMD_ACT 5'h01
`define DPRT_CMD_RD 5'h02
`define DPRT_CMD_WR 5'h04
`define DPRT_CMD_MWR 5'h06
`define DPRT_CMD_PRE 5'h10
// CA5 at first edge: all-bank for REF/PRE, auto precharge for RD/WR/MWR
`define DPRT_CA_ALL 5

// Register byte addresses
`define DPRT_A_CFG 8'h00
`define DPRT_A_LAT 8'h04
`define DPRT_A_CMD 8'h08
`define DPRT_A_STAT 8'h0C
`define DPRT_A_ROW 8'h10
`define DPRT_A_R2W 8'h14

// Configuration fields
`define DPRT_CFG_ODT 0
`define DPRT_CFG_BL32 1
`define DPRT_CFG_WPRE 2
`define DPRT_CFG_RPST 7
`define DPRT_CFG_NWR 8
`define DPRT_CFG_NRTP 16
`define DPRT_CFG_RST 32'h00080800
`define DPRT_LAT_RL 0
`define DPRT_LAT_WL 8
`define DPRT_LAT_ODTL 16
`define DPRT_LAT_RST 32'h00061020
`define DPRT_CMD_SRX 0
`define DPRT_CMD_CLR 1

// Status fields
`define DPRT_ST_CNT 0
`define DPRT_ST_DONE 8
`define DPRT_ST_BUSY 16
`define DPRT_ST_DUP 24
`define DPRT_ST_TIM 25
`define DPRT_R2W_OPEN 16

// Burst halves and rounded postamble / preamble in command clocks
`define DPRT_HALF_BL16 10'h008
`define DPRT_HALF_BL32 10'h010
`define DPRT_BL32_EXTRA 8'h08
`define DPRT_RPST_SHORT 10'h000
`define DPRT_RPST_LONG 10'h001
`define DPRT_WPRE_SHORT 10'h001
`define DPRT_WPRE_LONG 10'h002

`endif

//--- rtl/dprt_sync.v
`timescale 1ns/1ps
module dprt_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Asynchronous in, synchronous out
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta;

  always @(posedge clk)
  begin
    if (reset)
    begin
      meta <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

//--- rtl/dprt_bank.v
`timescale 1ns/1ps
module dprt_bank #(
  parameter [15:0] TRAS_CYC = 16'h0006,
  parameter [15:0] TRFC_CYC = 16'h0012
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Command clock edge enable
  input wire tick,
  // Commands aimed at this bank
  input wire act,
  input wire rdAp,
  input wire wrAp,
  input wire pre,
  input wire refPb,
  input wire [7:0] apDelay,
  // State
  output reg open,
  output reg busy,
  output reg autoPre
);

  reg [15:0] rasLeft;
  reg [15:0] refLeft;
  reg [7:0] apLeft;
  reg apPend;

  always @(posedge clk)
  begin
    if (reset)
    begin
      open <= 1'b0;
      busy <= 1'b0;
      autoPre <= 1'b0;
      rasLeft <= 16'h0000;
      refLeft <= 16'h0000;
      apLeft <= 8'h00;
      apPend <= 1'b0;
    end
    else
    begin
      autoPre <= 1'b0;
      if (rasLeft != 16'h0000)
        rasLeft <= rasLeft - 16'h0001;
      if (tick && apLeft != 8'h00)
        apLeft <= apLeft - 8'h01;
      if (refPb)
      begin
        refLeft <= TRFC_CYC;
        busy <= 1'b1;
      end
      else if (refLeft != 16'h0000)
      begin
        refLeft <= refLeft - 16'h0001;
        if (refLeft == 16'h0001)
          busy <= 1'b0;
      end
      if (act)
      begin
        open <= 1'b1;
        rasLeft <= TRAS_CYC;
        apPend <= 1'b0;
      end
      else if (pre)
      begin
        open <= 1'b0;
        apPend <= 1'b0;
      end
      else if ((rdAp || wrAp) && open)
      begin
        // Auto precharge may come right after tRCD; the lockout holds it
        apPend <= 1'b1;
        apLeft <= apDelay;
      end
      else if (apPend && apLeft == 8'h00 && rasLeft == 16'h0000)
      begin
        open <= 1'b0;
        apPend <= 1'b0;
        autoPre <= 1'b1;
      end
    end
  end

endmodule

//--- rtl/dprt_timing.v
// Functional notes
// - Back-to-back commands to other banks after auto precharge are accepted.
// - Read postamble follows config bit 7, write preamble config bit 2.
// - Read with auto precharge uses programmed nRTP.
// - Write with auto precharge uses programmed nWR.
// - Internal auto precharge waits until tRAS is met.
// - Refresh decodes from CS high and CA4..CA0 = 01000 at first edge.
// - CA5 at first edge selects per-bank (low) or all-bank (high).
// - Per-bank refresh bank is CA2..CA0 at second edge.
// - Eight per-bank refreshes accepted in any order, then a new set.
// - The set counts from the first per-bank refresh after synchronization.
// - Reset and self refresh exit clear the bank count.
// - All-bank refresh clears the bank count, at any point of a set.
// - All-bank refresh uses current row; next refresh uses incremented row.
// - A bank given a per-bank refresh is busy for tRFCpb, then idle; all-bank refresh sets no busy.
`timescale 1ns/1ps
`include "dprt_consts.vh"
module dprt_timing #(
  parameter TRAS_NS = 42,
  parameter TRFCPB_NS = 140,
  parameter [9:0] DQSCK_CYC = 10'h004,
  parameter [9:0] ODTON_CYC = 10'h001,
  parameter ROW_W = 14,
  parameter NBANK = 8
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // APB slave
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Command/address pins
  input wire ckIn,
  input wire csIn,
  input wire [5:0] caIn,
  // Bank state
  output wire [NBANK-1:0] bankOpen,
  output wire [NBANK-1:0] bankBusy,
  output wire [NBANK-1:0] autoPreDone,
  output reg [2:0] bankCount,
  output reg [ROW_W-1:0] rowCount
);

  localparam integer TRAS_RAW = (TRAS_NS + `DPRT_TCLK_NS - 1) / `DPRT_TCLK_NS;
  localparam integer TRFC_RAW = (TRFCPB_NS + `DPRT_TCLK_NS - 1) / `DPRT_TCLK_NS;
  localparam [15:0] TRAS_CYC = TRAS_RAW[15:0];
  localparam [15:0] TRFC_CYC = TRFC_RAW[15:0];
  localparam [1:0] ST_FIRST = 2'b01;
  localparam [1:0] ST_SECOND = 2'b10;

  function [NBANK-1:0] bankDec;
    input [2:0] b;
    begin
      bankDec = {{(NBANK-1){1'b0}}, 1'b1} << b;
    end
  endfunction

  wire [7:0] pinQ;
  wire linkCk = pinQ[7];
  wire linkCs = pinQ[6];
  wire [5:0] linkCa = pinQ[5:0];
  reg ckPrev;
  reg [1:0] state;
  reg [5:0] firstCa;
  reg [31:0] cfg;
  reg [31:0] lat;
  reg [NBANK-1:0] doneMask;
  reg dupErr;
  reg timErr;
  reg srxPulse;
  reg clrPulse;
  reg [9:0] r2wDelay;
  reg [9:0] r2wLeft;
  reg [2:0] r2wBank;

  dprt_sync #(
    .WIDTH(8)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .d({ckIn, csIn, caIn}),
    .q(pinQ)
  );

  // Pins change on the falling link edge, so they are settled at the rising one
  wire linkRise = linkCk & ~ckPrev;
  wire cmdGo = linkRise && state == ST_SECOND;
  wire [4:0] code = firstCa[4:0];
  wire allBit = firstCa[`DPRT_CA_ALL];
  wire [2:0] bank = linkCa[2:0];
  wire [NBANK-1:0] bankHot = bankDec(bank);
  wire isRef = cmdGo && code == `DPRT_CMD_REF;
  wire isRefPb = isRef && !allBit;
  wire isRefAb = isRef && allBit;
  wire isAct = cmdGo && code == `DPRT_CMD_ACT;
  wire isRd = cmdGo && code == `DPRT_CMD_RD;
  wire isWr = cmdGo && (code == `DPRT_CMD_WR || code == `DPRT_CMD_MWR);
  wire isPre = cmdGo && code == `DPRT_CMD_PRE;
  wire dupHit = isRefPb && (doneMask & bankHot) != {NBANK{1'b0}};

  // Command capture: first edge with CS high, bank on the next edge
  always @(posedge clk)
  begin
    if (reset)
    begin
      ckPrev <= 1'b0;
      state <= ST_FIRST;
      firstCa <= 6'h00;
    end
    else
    begin
      ckPrev <= linkCk;
      if (linkRise)
      begin
        case (state)
          ST_FIRST:
          begin
            if (linkCs)
            begin
              firstCa <= linkCa;
              state <= ST_SECOND;
            end
          end
          ST_SECOND:
          begin
            // Ready for a new command on the very next edge
            state <= ST_FIRST;
          end
          default:
          begin
            state <= ST_FIRST;
          end
        endcase
      end
    end
  end

  // Auto precharge delays in command clocks
  wire [7:0] nWr = cfg[`DPRT_CFG_NWR+7:`DPRT_CFG_NWR];
  wire [7:0] nRtp = cfg[`DPRT_CFG_NRTP+7:`DPRT_CFG_NRTP];
  wire bl32 = cfg[`DPRT_CFG_BL32];
  wire [7:0] rl = lat[`DPRT_LAT_RL+7:`DPRT_LAT_RL];
  wire [7:0] wl = lat[`DPRT_LAT_WL+7:`DPRT_LAT_WL];
  wire [7:0] odtl = lat[`DPRT_LAT_ODTL+7:`DPRT_LAT_ODTL];
  wire [9:0] half = bl32 ? `DPRT_HALF_BL32 : `DPRT_HALF_BL16;
  wire [7:0] rdApDelay = bl32 ? nRtp + `DPRT_BL32_EXTRA : nRtp;
  wire [7:0] wrApDelay = wl + half[7:0] + nWr + 8'h01;
  wire [7:0] apDelay = isRd ? rdApDelay : wrApDelay;
  wire [9:0] rpstCyc = cfg[`DPRT_CFG_RPST] ? `DPRT_RPST_LONG : `DPRT_RPST_SHORT;
  wire [9:0] wpreCyc = cfg[`DPRT_CFG_WPRE] ? `DPRT_WPRE_LONG : `DPRT_WPRE_SHORT;
  wire [9:0] readTail = {2'b00, rl} + DQSCK_CYC + half + rpstCyc;

  // Read-AP to other-bank write spacing, as the host must honour it
  always @(posedge clk)
  begin
    if (reset)
      r2wDelay <= 10'h000;
    else if (cfg[`DPRT_CFG_ODT])
      r2wDelay <= readTail - {2'b00, odtl} - ODTON_CYC + 10'h001;
    else
      r2wDelay <= readTail - {2'b00, wl} + wpreCyc;
  end

  wire apFlag = allBit && (isRd || isWr);
  wire [NBANK-1:0] actV = isAct ? bankHot : {NBANK{1'b0}};
  wire [NBANK-1:0] preV = !isPre ? {NBANK{1'b0}} : allBit ? {NBANK{1'b1}} : bankHot;
  wire [NBANK-1:0] rdApV = (isRd && apFlag) ? bankHot : {NBANK{1'b0}};
  wire [NBANK-1:0] wrApV = (isWr && apFlag) ? bankHot : {NBANK{1'b0}};
  // A refused duplicate refresh leaves the bank untouched
  wire [NBANK-1:0] refV = (isRefPb && !dupHit) ? bankHot : {NBANK{1'b0}};

  genvar g;
  generate
    for (g = 0; g < NBANK; g = g + 1)
    begin : g_bank
      dprt_bank #(
        .TRAS_CYC(TRAS_CYC),
        .TRFC_CYC(TRFC_CYC)
      ) u_bank (
        .clk(clk),
        .reset(reset),
        .tick(linkRise),
        .act(actV[g]),
        .rdAp(rdApV[g]),
        .wrAp(wrApV[g]),
        .pre(preV[g]),
        .refPb(refV[g]),
        .apDelay(apDelay),
        .open(bankOpen[g]),
        .busy(bankBusy[g]),
        .autoPre(autoPreDone[g])
      );
    end
  endgenerate

  // Refresh bank count, done record and row counter
  always @(posedge clk)
  begin
    if (reset || srxPulse)
    begin
      bankCount <= 3'h0;
      doneMask <= {NBANK{1'b0}};
      if (reset)
        rowCount <= {ROW_W{1'b0}};
    end
    else if (isRefAb)
    begin
      bankCount <= 3'h0;
      doneMask <= {NBANK{1'b0}};
      rowCount <= rowCount + {{(ROW_W-1){1'b0}}, 1'b1};
    end
    else if (isRefPb && !dupHit)
    begin
      if (bankCount == 3'h7)
      begin
        // Set complete: any order allowed for the next set
        bankCount <= 3'h0;
        doneMask <= {NBANK{1'b0}};
        rowCount <= rowCount + {{(ROW_W-1){1'b0}}, 1'b1};
      end
      else
      begin
        bankCount <= bankCount + 3'h1;
        doneMask <= doneMask | bankHot;
      end
    end
  end

  // Sticky violation flags; a new event beats a clear in the same cycle
  always @(posedge clk)
  begin
    if (reset)
    begin
      dupErr <= 1'b0;
      timErr <= 1'b0;
      r2wLeft <= 10'h000;
      r2wBank <= 3'h0;
    end
    else
    begin
      if (clrPulse)
      begin
        dupErr <= 1'b0;
        timErr <= 1'b0;
      end
      if (dupHit)
        dupErr <= 1'b1;
      if (isWr && r2wLeft != 10'h000 && bank != r2wBank)
        timErr <= 1'b1;
      if (isRd && apFlag)
      begin
        r2wLeft <= (r2wDelay == 10'h000) ? 10'h000 : r2wDelay - 10'h001;
        r2wBank <= bank;
      end
      else if (linkRise && r2wLeft != 10'h000)
        r2wLeft <= r2wLeft - 10'h001;
    end
  end

  // APB: one wait-free access phase, data captured in the setup cycle
  reg [31:0] rdMux;
  reg hit;

  always @*
  begin
    rdMux = 32'h00000000;
    hit = 1'b1;
    case (paddr)
      `DPRT_A_CFG: rdMux = cfg;
      `DPRT_A_LAT: rdMux = lat;
      `DPRT_A_CMD: rdMux = 32'h00000000;
      `DPRT_A_STAT:
      begin
        rdMux[`DPRT_ST_CNT+2:`DPRT_ST_CNT] = bankCount;
        rdMux[`DPRT_ST_DONE+NBANK-1:`DPRT_ST_DONE] = doneMask;
        rdMux[`DPRT_ST_BUSY+NBANK-1:`DPRT_ST_BUSY] = bankBusy;
        rdMux[`DPRT_ST_DUP] = dupErr;
        rdMux[`DPRT_ST_TIM] = timErr;
      end
      `DPRT_A_ROW: rdMux[ROW_W-1:0] = rowCount;
      `DPRT_A_R2W:
      begin
        rdMux[9:0] = r2wDelay;
        rdMux[`DPRT_R2W_OPEN+NBANK-1:`DPRT_R2W_OPEN] = bankOpen;
      end
      default: hit = 1'b0;
    endcase
  end

  wire wrTake = psel && penable && pready && pwrite;

  always @(posedge clk)
  begin
    if (reset)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cfg <= `DPRT_CFG_RST;
      lat <= `DPRT_LAT_RST;
      srxPulse <= 1'b0;
      clrPulse <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      srxPulse <= 1'b0;
      clrPulse <= 1'b0;
      if (psel && !penable)
      begin
        prdata <= pwrite ? 32'h00000000 : rdMux;
        pslverr <= !hit;
      end
      if (wrTake && hit)
      begin
        case (paddr)
          `DPRT_A_CFG: cfg <= pwdata;
          `DPRT_A_LAT: lat <= pwdata;
          `DPRT_A_CMD:
          begin
            srxPulse <= pwdata[`DPRT_CMD_SRX];
            clrPulse <= pwdata[`DPRT_CMD_CLR];
          end
          default: cfg <= cfg;
        endcase
      end
    end
  end

endmodule

//--- verification/dprt_timing_sva.sv
`timescale 1ns/1ps
`include "dprt_consts.vh"
module dprt_timing_sva #(
  parameter TRFCPB_NS = 140,
  parameter ROW_W = 14,
  parameter NBANK = 8
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // APB
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Link pins
  input wire ckIn,
  input wire csIn,
  input wire [5:0] caIn,
  // State
  input wire [NBANK-1:0] bankOpen,
  input wire [NBANK-1:0] bankBusy,
  input wire [NBANK-1:0] autoPreDone,
  input wire [2:0] bankCount,
  input wire [ROW_W-1:0] rowCount
);
  localparam int BUSY_CYC = (TRFCPB_NS + `DPRT_TCLK_NS - 1) / `DPRT_TCLK_NS;
  wire anyBusy = |bankBusy;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_rdy;
    psel && !penable |=> pready && penable;
  endproperty
  a_rdy: assert property (p_rdy) else $error("access phase not answered in one cycle");
  property p_err;
    pready && paddr > `DPRT_A_R2W |-> pslverr && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_busy_cnt;
    $rose(anyBusy) |-> $onehot(bankBusy) && bankCount != $past(bankCount);
  endproperty
  a_busy_cnt: assert property (p_busy_cnt) else $error("busy bank without count step");
  property p_busy_len;
    $fell(anyBusy) |-> $past(anyBusy, BUSY_CYC) && !$past(anyBusy, BUSY_CYC + 1);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("refresh busy length wrong");
  property p_cnt_step;
    $changed(bankCount) |-> bankCount == $past(bankCount) + 3'h1 || bankCount == 3'h0;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("bank count jumped");
  property p_row_step;
    $changed(rowCount) |-> rowCount == $past(rowCount) + 1'b1;
  endproperty
  a_row_step: assert property (p_row_step) else $error("row counter jumped");
  property p_full_row;
    $rose(anyBusy) && bankCount == 3'h0 |-> rowCount == $past(rowCount) + 1'b1;
  endproperty
  a_full_row: assert property (p_full_row) else $error("full set kept row");
  property p_ap_pulse;
    |autoPreDone |=> (autoPreDone & $past(autoPreDone)) == 0;
  endproperty
  a_ap_pulse: assert property (p_ap_pulse) else $error("close pulse too long");
endmodule
bind dprt_timing dprt_timing_sva #(.TRFCPB_NS(TRFCPB_NS), .ROW_W(ROW_W), .NBANK(NBANK)) chkU (
  .clk(clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ckIn(ckIn), .csIn(csIn), .caIn(caIn), .bankOpen(bankOpen), .bankBusy(bankBusy),
  .autoPreDone(autoPreDone), .bankCount(bankCount), .rowCount(rowCount)
);

//--- verification/dprt_host_model.sv
`timescale 1ns/1ps
module dprt_host_model (
  // Command/address pins
  output logic ckIn,
  output logic csIn,
  output logic [5:0] caIn
);
  initial
  begin
    ckIn = 1'b0;
    csIn = 1'b0;
    caIn = 6'h00;
  end
  // Pins move on the falling link edge; the clock stands still between frames
  task frame(input logic cs, input logic [5:0] a, input logic [5:0] b);
    csIn <= cs;
    caIn <= a;
    #62.5 ckIn <= 1'b1;
    #62.5 ckIn <= 1'b0;
    csIn <= 1'b0;
    caIn <= b;
    #62.5 ckIn <= 1'b1;
    #62.5 ckIn <= 1'b0;
    caIn <= ~b;
  endtask
  task ref_pb(input logic [2:0] bank);
    frame(1'b1, 6'h08, {3'h0, bank});
  endtask
  task ref_ab;
    frame(1'b1, 6'h28, 6'h00);
  endtask
  // Deselected frames give the device link edges to count
  task idle(input int n);
    repeat (n) frame(1'b0, 6'h00, 6'h00);
  endtask
endmodule

//--- verification/dprt_timing_test.sv
`timescale 1ns/1ps
`include "dprt_consts.vh"
module dprt_timing_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire ckIn;
  wire csIn;
  wire [5:0] caIn;
  wire [7:0] bankOpen;
  wire [7:0] bankBusy;
  wire [7:0] autoPreDone;
  wire [2:0] bankCount;
  wire [13:0] rowCount;
  logic [31:0] rdData;
  logic rdErr;
  logic [7:0] apSeen = 8'h00;
  logic [7:0] doneMask;
  logic [13:0] row0;
  logic [2:0] order [8] = '{3'h1, 3'h3, 3'h0, 3'h2, 3'h4, 3'h7, 3'h5, 3'h6};
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  dprt_timing dut_u (
    .clk(clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ckIn(ckIn), .csIn(csIn), .caIn(caIn), .bankOpen(bankOpen), .bankBusy(bankBusy),
    .autoPreDone(autoPreDone), .bankCount(bankCount), .rowCount(rowCount)
  );
  dprt_host_model hostU (.ckIn(ckIn), .csIn(csIn), .caIn(caIn));
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    apSeen <= apSeen | autoPreDone;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      end_sim;
    end
  end
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Waits on pready without assuming the slave's latency
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the cycle watchdog ends a hung wait
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, `DPRT_A_CFG, 32'h0);
    check("cfg", rdData, `DPRT_CFG_RST);
    apb(1'b0, `DPRT_A_LAT, 32'h0);
    check("lat", rdData, `DPRT_LAT_RST);
    apb(1'b1, `DPRT_A_ROW, 32'h3FFF);
    apb(1'b0, `DPRT_A_STAT, 32'h0);
    check("stat", rdData, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", {31'h0, rdErr}, 32'h1);
    apb(1'b0, `DPRT_A_ROW, 32'h0);
    check("row ro", rdData, 32'h0);
    row0 = rowCount;
    doneMask = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      hostU.ref_pb(order[i]);
      check("busy", bankBusy, 32'h1 << order[i]);
      doneMask = (i == 7) ? 8'h00 : doneMask | (8'h01 << order[i]);
      apb(1'b0, `DPRT_A_STAT, 32'h0);
      check("count", rdData[2:0], (i + 1) % 8);
      check("done", rdData[15:8], doneMask);
      repeat (12) @(posedge clk);
      check("idle", bankBusy, 32'h0);
    end
    check("row set", rowCount, row0 + 1'b1);
    hostU.ref_pb(3'h6);
    hostU.ref_pb(3'h6);
    check("dup busy", bankBusy, 32'h0);
    apb(1'b0, `DPRT_A_STAT, 32'h0);
    check("dup count", rdData[2:0], 32'h1);
    check("dup flag", rdData[`DPRT_ST_DUP], 32'h1);
    apb(1'b1, `DPRT_A_CMD, 32'h2);
    apb(1'b0, `DPRT_A_STAT, 32'h0);
    check("dup clr", rdData[`DPRT_ST_DUP], 32'h0);
    row0 = rowCount;
    hostU.ref_ab;
    repeat (4) @(posedge clk);
    check("ab count", bankCount, 32'h0);
    check("ab row", rowCount, row0 + 1'b1);
    hostU.ref_pb(3'h0);
    check("pb after ab", {bankCount, rowCount}, {3'h1, row0 + 1'b1});
    apb(1'b1, `DPRT_A_CMD, 32'h1);
    repeat (2) @(posedge clk);
    check("srx", {bankCount, rowCount}, {3'h0, row0 + 1'b1});
    hostU.frame(1'b1, 6'h01, 6'h05);
    check("act", bankOpen, 32'h20);
    hostU.frame(1'b1, 6'h22, 6'h05);
    hostU.idle(1);
    check("rtp hold", bankOpen, 32'h20);
    hostU.idle(4);
    repeat (8) @(posedge clk);
    check("ap close", {bankOpen, apSeen}, 32'h0020);
    // RL 32 + DQSCK 4 + BL/2 8 + RPST 0 - WL 16 + WPRE 1
    apb(1'b0, `DPRT_A_R2W, 32'h0);
    check("r2w", rdData, 32'h1D);
    apb(1'b1, `DPRT_A_CFG, `DPRT_CFG_RST | 32'h1);
    // RL 32 + DQSCK 4 + BL/2 8 + RPST 0 - ODTLon 6 - ODTon 1 + 1
    apb(1'b0, `DPRT_A_R2W, 32'h0);
    check("r2w odt", rdData, 32'h26);
    hostU.frame(1'b1, 6'h22, 6'h01);
    hostU.frame(1'b1, 6'h04, 6'h02);
    apb(1'b0, `DPRT_A_STAT, 32'h0);
    check("too soon", rdData[`DPRT_ST_TIM], 32'h1);
    end_sim;
  end
endmodule
